// *** common/spi_pkg.sv ***
/*
  Shared constants of the serial peripheral port: register offsets, field
  positions, reset values, operating modes and clock divider counts.
  Assumes a 100 MHz system clock and an 8-bit register port with 2 address bits.
*/
package spi_pkg;
  // Register offsets
  localparam logic [1:0] ADDR_CTRL0 = 2'h0;
  localparam logic [1:0] ADDR_CTRL2 = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;
  // port_control_reg0 fields
  localparam int C0_MODE_LSB = 5;
  localparam int C0_ENABLE = 1;
  localparam logic [2:0] MODE_RESET = 3'h7;
  // port_control_reg2 fields
  localparam int C2_EDGE = 5;
  localparam int C2_POLARITY = 4;
  localparam int C2_ORDER = 3;
  localparam int C2_SEL_EN = 2;
  localparam int C2_COLLISION = 1;
  localparam int C2_DONE = 0;
  // operating_mode_field codes
  localparam logic [2:0] MODE_SYS_DIV4 = 3'h0;
  localparam logic [2:0] MODE_SYS_DIV16 = 3'h1;
  localparam logic [2:0] MODE_SYS_DIV64 = 3'h2;
  localparam logic [2:0] MODE_SUB = 3'h3;
  localparam logic [2:0] MODE_TIMER = 3'h4;
  localparam logic [2:0] MODE_SLAVE = 3'h5;
  // Word framing
  localparam int WORD_BITS = 8;
  localparam logic [3:0] LAST_HALF_EDGE = 4'hF;
  localparam logic [3:0] LAST_SLAVE_BIT = 4'h7;
  // Half-period lengths in system clocks; the divider reloads at length minus one
  localparam int HALF_DIV4 = 2;
  localparam int HALF_DIV16 = 8;
  localparam int HALF_DIV64 = 32;
  localparam logic [4:0] LAST_DIV4 = 5'(HALF_DIV4 - 1);
  localparam logic [4:0] LAST_DIV16 = 5'(HALF_DIV16 - 1);
  localparam logic [4:0] LAST_DIV64 = 5'(HALF_DIV64 - 1);
  // Synchroniser lanes and their levels after reset
  localparam int LANE_SCK = 0;
  localparam int LANE_SDI = 1;
  localparam int LANE_SEL = 2;
  localparam logic [2:0] PIN_RESET = 3'h4;
endpackage

// *** common/spi_tick_if.sv ***
/*
  Carries the master clock request from the port engine to the half-period
  divider and the half-period pulse back.
  Assumes both ends run on the system clock.
*/
interface spi_tick_if;
  logic [2:0] mode;
  logic run;
  logic sub_tick;
  logic timer_tick;
  logic half_tick;
  modport gen (input mode, input run, input sub_tick, input timer_tick, output half_tick);
  modport engine (output mode, output run, output sub_tick, output timer_tick, input half_tick);
endinterface

// *** rtl/spi_half_tick.sv ***
/*
  Half-period pulse generator for master operation: divides the system clock
  or passes on the sub-clock or timer ticks.
  Assumes the tick inputs are one-cycle pulses on the system clock.
*/
module spi_half_tick (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Request and pulse
  spi_tick_if.gen bus
);
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } div_state_s;

  div_state_s st_r;
  div_state_s st_nxt;
  logic [4:0] last_c;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    case (bus.mode)
      spi_pkg::MODE_SYS_DIV4: last_c = spi_pkg::LAST_DIV4;
      spi_pkg::MODE_SYS_DIV16: last_c = spi_pkg::LAST_DIV16;
      default: last_c = spi_pkg::LAST_DIV64;
    endcase
    // Restarting from zero keeps each divided-mode word's first half period full length
    if (!bus.run) begin
      st_nxt.cnt = 5'h00;
    end else if (bus.mode == spi_pkg::MODE_SUB) begin
      st_nxt.tick = bus.sub_tick;
    end else if (bus.mode == spi_pkg::MODE_TIMER) begin
      st_nxt.tick = bus.timer_tick;
    end else if (st_r.cnt == last_c) begin
      st_nxt.cnt = 5'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 5'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.half_tick = st_r.tick;
endmodule

// *** rtl/spi_master_slave_port.sv ***
/*
  Serial peripheral port that works as bus master or slave, exchanging 8-bit
  words through one shared data register and a shift buffer.
  Assumes a 100 MHz system clock, a synchronous register port, and pins that
  a pad multiplexer hands to this block while o_port_active is high.
*/
// Summary of operation
// - Data write while busy: collision, write dropped
// - Collision flag stays set until software clears
// - Word end sets done flag until cleared
// - Word end also pulses the interrupt request
// - Master data write starts full-duplex exchange
// - Master makes the clock, only after loading
// - Slave shifts only on external master clocks
// - Received bits reach data register when complete
// - Select enabled: select line gates the slave, master drives it
// - Select disabled: select line floats, ignored
// - Port disabled: all four pins released
// - Slave output timed by polarity and edge
// - Both ends use same bit order
// - Keeps running while its clock source runs
// - Four lines: clock, in, out, select
// - Mode codes 000-100 master, 101 slave
// - Eight-bit data register and word
module spi_master_slave_port (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Register port
  input wire logic [1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Master clock sources
  input wire logic i_sub_half_tick,
  input wire logic i_timer_tick,
  // Interrupt request
  output logic o_xfer_irq,
  // Serial clock pin
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  // Serial data pins
  input wire logic i_serial_in_line,
  output logic o_serial_out_line,
  output logic o_serial_out_oe,
  // Select pin
  input wire logic i_slave_select_n,
  output logic o_slave_select_n,
  output logic o_slave_select_oe,
  // Pin ownership towards the pad multiplexer
  output logic o_port_active
);
  typedef struct packed {
    logic [2:0] mode;
    logic en;
    logic edge_sel;
    logic pol;
    logic order;
    logic sel_en;
    logic collision;
    logic done;
    logic [7:0] data;
    logic [7:0] shift;
    logic busy;
    logic [3:0] edges;
    logic sck;
    logic serial_out_line;
    logic sck_prev;
    logic irq;
    logic [7:0] rdata;
  } port_state_s;

  localparam port_state_s RESET_S = '{mode: spi_pkg::MODE_RESET, default: '0};

  port_state_s st_r;
  port_state_s st_nxt;
  logic [2:0] pin_level;
  logic sck_f;
  logic sdi_f;
  logic sel_f;
  logic master_c;
  logic slave_c;
  logic selected_c;
  logic sck_moved_c;
  logic lead_c;
  logic trail_c;
  logic slave_cap_c;
  logic slave_launch_c;
  logic wr_data_c;
  logic done_c;

  spi_tick_if tick_bus ();

  function automatic logic is_master(input logic [2:0] mode);
    return mode <= spi_pkg::MODE_TIMER;
  endfunction

  function automatic logic out_bit(input logic [7:0] word, input logic msb_first);
    return msb_first ? word[spi_pkg::WORD_BITS - 1] : word[0];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] word, input logic msb_first,
                                          input logic din);
    return msb_first ? {word[6:0], din} : {din, word[7:1]};
  endfunction

  // Every pin input goes through the filter; this limits the usable bit rate
  spi_pin_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_pins ({i_slave_select_n, i_serial_in_line, i_sck}),
    .o_level (pin_level)
  );

  spi_half_tick u_div (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .bus (tick_bus)
  );

  assign tick_bus.mode = st_r.mode;
  assign tick_bus.run = st_r.busy && st_r.en && master_c;
  // Sub-clock and timer ticks keep the port alive while the core idles
  assign tick_bus.sub_tick = i_sub_half_tick;
  assign tick_bus.timer_tick = i_timer_tick;

  assign sck_f = pin_level[spi_pkg::LANE_SCK];
  assign sdi_f = pin_level[spi_pkg::LANE_SDI];
  assign sel_f = pin_level[spi_pkg::LANE_SEL];
  assign master_c = is_master(st_r.mode);
  assign slave_c = st_r.mode == spi_pkg::MODE_SLAVE;
  assign selected_c = !st_r.sel_en || !sel_f;
  assign sck_moved_c = sck_f != st_r.sck_prev;
  assign lead_c = sck_moved_c && (sck_f != st_r.pol);
  assign trail_c = sck_moved_c && (sck_f == st_r.pol);
  assign slave_cap_c = st_r.edge_sel ? lead_c : trail_c;
  assign slave_launch_c = st_r.edge_sel ? trail_c : lead_c;
  assign wr_data_c = i_reg_wr && (i_reg_addr == spi_pkg::ADDR_DATA);

  always_comb begin
    st_nxt = st_r;
    st_nxt.irq = 1'b0;
    st_nxt.rdata = 8'h00;
    st_nxt.sck_prev = sck_f;
    done_c = 1'b0;

    if (i_reg_wr && i_reg_addr == spi_pkg::ADDR_CTRL0) begin
      st_nxt.mode = i_reg_wdata[spi_pkg::C0_MODE_LSB +: 3];
      st_nxt.en = i_reg_wdata[spi_pkg::C0_ENABLE];
    end
    if (i_reg_wr && i_reg_addr == spi_pkg::ADDR_CTRL2) begin
      st_nxt.edge_sel = i_reg_wdata[spi_pkg::C2_EDGE];
      st_nxt.pol = i_reg_wdata[spi_pkg::C2_POLARITY];
      st_nxt.order = i_reg_wdata[spi_pkg::C2_ORDER];
      st_nxt.sel_en = i_reg_wdata[spi_pkg::C2_SEL_EN];
      // Writing one leaves a flag alone; only hardware sets them
      st_nxt.collision = st_r.collision && i_reg_wdata[spi_pkg::C2_COLLISION];
      st_nxt.done = st_r.done && i_reg_wdata[spi_pkg::C2_DONE];
    end

    if (st_r.en && master_c) begin
      if (!st_r.busy) begin
        st_nxt.sck = st_r.pol;
        st_nxt.edges = 4'h0;
      end else if (tick_bus.half_tick) begin
        st_nxt.sck = !st_r.sck;
        st_nxt.edges = st_r.edges + 4'h1;
        // Even half edges lead; edge_sel picks which kind samples
        if (st_r.edges[0] != st_r.edge_sel) begin
          st_nxt.shift = shift_in(st_r.shift, st_r.order, sdi_f);
        end else begin
          st_nxt.serial_out_line = out_bit(st_r.shift, st_r.order);
        end
        if (st_r.edges == spi_pkg::LAST_HALF_EDGE) begin
          st_nxt.busy = 1'b0;
          st_nxt.edges = 4'h0;
          done_c = 1'b1;
          st_nxt.data = st_nxt.shift;
        end
      end
    end else if (st_r.en && slave_c) begin
      if (!selected_c) begin
        st_nxt.edges = 4'h0;
        st_nxt.busy = 1'b0;
      end else if (slave_cap_c) begin
        st_nxt.shift = shift_in(st_r.shift, st_r.order, sdi_f);
        st_nxt.edges = st_r.edges + 4'h1;
        st_nxt.busy = 1'b1;
        if (st_r.edges == spi_pkg::LAST_SLAVE_BIT) begin
          st_nxt.edges = 4'h0;
          st_nxt.busy = 1'b0;
          done_c = 1'b1;
          st_nxt.data = st_nxt.shift;
        end
      end else if (slave_launch_c) begin
        st_nxt.serial_out_line = out_bit(st_r.shift, st_r.order);
      end
      // Leading-edge capture needs the first bit before the first edge
      if (!st_nxt.busy && st_r.edge_sel) begin
        st_nxt.serial_out_line = out_bit(st_nxt.shift, st_r.order);
      end
    end else begin
      st_nxt.busy = 1'b0;
      st_nxt.edges = 4'h0;
      st_nxt.sck = st_r.pol;
    end

    if (done_c) begin
      st_nxt.done = 1'b1;
      st_nxt.irq = 1'b1;
    end

    if (wr_data_c) begin
      // A word that starts or ends in this cycle also counts as busy
      if (st_r.busy || st_nxt.busy) begin
        st_nxt.collision = 1'b1;
      end else begin
        st_nxt.data = i_reg_wdata;
        st_nxt.shift = i_reg_wdata;
        st_nxt.serial_out_line = out_bit(i_reg_wdata, st_r.order);
        if (st_r.en && master_c) begin
          st_nxt.busy = 1'b1;
          st_nxt.edges = 4'h0;
        end
      end
    end

    if (i_reg_rd) begin
      case (i_reg_addr)
        spi_pkg::ADDR_CTRL0: begin
          st_nxt.rdata[spi_pkg::C0_MODE_LSB +: 3] = st_r.mode;
          st_nxt.rdata[spi_pkg::C0_ENABLE] = st_r.en;
        end
        spi_pkg::ADDR_CTRL2: begin
          st_nxt.rdata[spi_pkg::C2_EDGE] = st_r.edge_sel;
          st_nxt.rdata[spi_pkg::C2_POLARITY] = st_r.pol;
          st_nxt.rdata[spi_pkg::C2_ORDER] = st_r.order;
          st_nxt.rdata[spi_pkg::C2_SEL_EN] = st_r.sel_en;
          st_nxt.rdata[spi_pkg::C2_COLLISION] = st_r.collision;
          st_nxt.rdata[spi_pkg::C2_DONE] = st_r.done;
        end
        spi_pkg::ADDR_DATA: st_nxt.rdata = st_r.data;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_r <= RESET_S;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_reg_rdata = st_r.rdata;
  assign o_xfer_irq = st_r.irq;
  assign o_sck = st_r.sck;
  assign o_serial_out_line = st_r.serial_out_line;
  assign o_slave_select_n = !st_r.busy;
  // Modes 110 and 111 are not this port, so they release the pins as well
  assign o_port_active = st_r.en && (master_c || slave_c);
  assign o_sck_oe = st_r.en && master_c;
  assign o_serial_out_oe = st_r.en && (master_c || (slave_c && selected_c));
  assign o_slave_select_oe = st_r.en && master_c && st_r.sel_en;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  AST_COLLISION_SET: assert property (
    wr_data_c && st_r.busy |=> st_r.collision)
    else $error("data write during a transfer did not flag a collision");

  AST_COLLISION_DROP: assert property (
    wr_data_c && st_r.busy && !done_c |=> $stable(st_r.data) && st_r.busy)
    else $error("colliding write disturbed the transfer");

  AST_COLLISION_STICKY: assert property (
    st_r.collision && !(i_reg_wr && i_reg_addr == spi_pkg::ADDR_CTRL2 && !i_reg_wdata[spi_pkg::C2_COLLISION])
    |=> st_r.collision)
    else $error("collision flag cleared without software");

  AST_DONE_FLAG: assert property (
    done_c |=> st_r.done)
    else $error("word end did not set the done flag");

  AST_IRQ_PULSE: assert property (
    done_c |=> o_xfer_irq ##1 !o_xfer_irq)
    else $error("interrupt request not a single pulse after word end");

  AST_MASTER_START: assert property (
    wr_data_c && st_r.en && master_c && !st_r.busy
    |=> st_r.busy && st_r.data == $past(i_reg_wdata) && o_sck == st_r.pol)
    else $error("master data write did not start an exchange");

  AST_MASTER_LENGTH: assert property (
    $rose(st_r.busy) && master_c && st_r.mode == spi_pkg::MODE_SYS_DIV4
    |-> st_r.busy [*8] ##25 st_r.busy ##1 !st_r.busy && st_r.done)
    else $error("fastest master word did not take 16 half periods");

  AST_SCK_IDLE: assert property (
    st_r.en && master_c && !st_r.busy && $stable(st_r.pol) && $past(st_r.en) |-> o_sck == st_r.pol)
    else $error("master clock moved outside a transfer");

  AST_RX_HOLD: assert property (
    st_r.busy && !done_c |=> $stable(st_r.data))
    else $error("data register changed before the word was complete");

  AST_PORT_RELEASE: assert property (
    !st_r.en |-> !o_sck_oe && !o_serial_out_oe && !o_slave_select_oe && !o_port_active)
    else $error("disabled port still drives its pins");

  AST_SELECT_IGNORED: assert property (
    !st_r.sel_en |-> !o_slave_select_oe)
    else $error("select line driven while select is disabled");

  AST_DESELECT_IDLE: assert property (
    st_r.en && slave_c && st_r.sel_en && sel_f |-> !o_serial_out_oe ##1 (st_r.edges == 4'h0 && !st_r.busy))
    else $error("deselected slave reacted to the bus");

  COV_MASTER_WORD: cover property (
    $rose(st_r.busy) && master_c ##[1:600] done_c);

  COV_SLAVE_WORD: cover property (
    slave_c && slave_cap_c ##[1:900] done_c);

  COV_COLLISION: cover property (
    wr_data_c && st_r.busy);

  COV_DESELECT: cover property (
    slave_c && st_r.busy && st_r.sel_en && sel_f);
endmodule

// *** rtl/spi_pin_sync.sv ***
/*
  Three-stage synchroniser with agreement filter for the clock, data-in and
  select pins.
  Assumes the pins are asynchronous to the system clock.
*/
module spi_pin_sync (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Pins and filtered levels
  input wire logic [2:0] i_pins,
  output logic [2:0] o_level
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;
  } sync_state_s;

  localparam sync_state_s RESET_S = '{spi_pkg::PIN_RESET, spi_pkg::PIN_RESET,
                                      spi_pkg::PIN_RESET, spi_pkg::PIN_RESET};

  sync_state_s st_r;
  sync_state_s st_nxt;
  logic [2:0] agree_c;

  // The first stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    agree_c = ~(st_r.s2 ^ st_r.s3);
    st_nxt.filt = (st_r.s2 & agree_c) | (st_r.filt & ~agree_c);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_r <= RESET_S;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.filt;
endmodule

// *** verif/spi_far_model.sv ***
/*
  Far side of the serial port: answers as a slave on the port's clock, or
  runs one frame as master through run_master.
  Assumes the bench resolves the clock, select and data-out pins from the port's enables.
*/
module spi_far_model (
  // Clock
  input wire logic i_clk_sys,
  // Setup from the bench
  input wire logic i_arm,
  input wire logic i_order,
  input wire logic i_edge,
  input wire logic i_pol,
  input wire logic [7:0] i_tx,
  // Wire levels
  input wire logic i_sck,
  input wire logic i_sdo,
  // Driven lines and result
  output logic o_sck,
  output logic o_sdi,
  output logic o_sel_n,
  output logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev = 1'b0;
  logic mst = 1'b0;
  int idx = 0;
  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b0;
    o_sel_n = 1'b1;
    o_rx = 8'h00;
  end
  function automatic logic pick(input int k);
    return i_order ? i_tx[7 - k] : i_tx[k];
  endfunction
  function automatic logic [7:0] shin(input logic [7:0] r, input logic b);
    return i_order ? {r[6:0], b} : {b, r[7:1]};
  endfunction
  // Slave role: capture on the edge the port captures on, launch on the other
  always @(posedge i_clk_sys) begin
    prev <= i_sck;
    if (!mst) o_sck <= i_pol;
    if (!mst && i_arm) begin
      idx <= i_edge ? 1 : 0;
      if (i_edge) o_sdi <= pick(0);
    end else if (!mst && i_sck != prev) begin
      if ((i_sck != i_pol) == i_edge) o_rx <= shin(o_rx, i_sdo);
      else if (idx < 8) begin
        o_sdi <= pick(idx);
        idx <= idx + 1;
      end else begin
        // Past the word the line must not keep showing the last bit
        o_sdi <= ~o_sdi;
      end
    end
  end
  // Master role: each clock level lasts 8 cycles, well above the pin filter delay
  task automatic run_master(input logic use_sel, output logic [7:0] rx);
    rx = 8'h00;
    mst = 1'b1;
    @(posedge i_clk_sys);
    o_sel_n <= ~use_sel;
    if (i_edge) o_sdi <= pick(0);
    repeat (8) @(posedge i_clk_sys);
    for (int k = 0; k < 8; k++) begin
      o_sck <= ~i_pol;
      if (i_edge) rx = shin(rx, i_sdo);
      else o_sdi <= pick(k);
      repeat (8) @(posedge i_clk_sys);
      o_sck <= i_pol;
      if (!i_edge) rx = shin(rx, i_sdo);
      else if (k < 7) o_sdi <= pick(k + 1);
      repeat (8) @(posedge i_clk_sys);
    end
    o_sel_n <= 1'b1;
    o_sdi <= ~o_sdi;
    mst = 1'b0;
  endtask
endmodule

// *** verif/spi_master_slave_port_test.sv ***
/*
  Self-checking bench of the serial port: register tasks, frames in every
  master mode and in every slave clock shape against the far-side model.
  Assumes read data stand in the cycle after the read strobe.
*/
module spi_master_slave_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, wr, rd, sub_tick, tmr_tick, irq, arm, pol, eg, ord;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, mtx, m_rx, mrx;
  logic sck_o, sck_oe, sdo_o, sdo_oe, sel_o, sel_oe, active, m_sck, m_sdi, m_sel_n;
  wire sck_w = sck_oe ? sck_o : m_sck;
  wire sel_w = sel_oe ? sel_o : m_sel_n;
  // A released data line rests at its pull-up level
  wire sdo_w = sdo_oe ? sdo_o : 1'b1;
  int n_fail = 0;
  int n_checks = 0;
  int cnt = 0;
  spi_master_slave_port spi_master_slave_port_inst (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_sub_half_tick(sub_tick), .i_timer_tick(tmr_tick),
    .o_xfer_irq(irq), .i_sck(sck_w), .o_sck(sck_o), .o_sck_oe(sck_oe), .i_serial_in_line(m_sdi),
    .o_serial_out_line(sdo_o), .o_serial_out_oe(sdo_oe), .i_slave_select_n(sel_w),
    .o_slave_select_n(sel_o), .o_slave_select_oe(sel_oe), .o_port_active(active));
  spi_far_model spi_far_model_inst (
    .i_clk_sys(clk), .i_arm(arm), .i_order(ord), .i_edge(eg), .i_pol(pol), .i_tx(mtx),
    .i_sck(sck_w), .i_sdo(sdo_w), .o_sck(m_sck), .o_sdi(m_sdi), .o_sel_n(m_sel_n), .o_rx(m_rx));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Source ticks slow enough that received bits clear the pin filter
  always @(posedge clk) begin
    cnt <= cnt + 1;
    sub_tick <= (cnt % 12 == 0);
    tmr_tick <= (cnt % 10 == 0);
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // One idle edge keeps the strobe from being lowered and raised in one step
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [1:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    rd_reg(a, v);
    chk(nm, v, e);
  endtask
  task automatic load(input logic [7:0] d);
    arm <= 1'b1;
    wr_reg(spi_pkg::ADDR_DATA, d);
    arm <= 1'b0;
  endtask
  task automatic wait_irq;
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (irq !== 1'b1 && k < 3000);
    chk("irq", {7'h0, irq}, 8'h01);
    @(negedge clk);
    chk("irq pulse", {7'h0, irq}, 8'h00);
    @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    logic [7:0] tx, c2;
    logic lp, le, lo, cs;
    rst_n = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    arm = 1'b0;
    sub_tick = 1'b0;
    tmr_tick = 1'b0;
    pol = 1'b0;
    eg = 1'b0;
    ord = 1'b0;
    mtx = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(spi_pkg::ADDR_CTRL0, {spi_pkg::MODE_RESET, 5'h00}, "ctrl0 reset");
    rchk(spi_pkg::ADDR_CTRL2, 8'h00, "ctrl2 reset");
    rchk(spi_pkg::ADDR_DATA, 8'h00, "data reset");
    rchk(2'h3, 8'h00, "unmapped read");
    wr_reg(2'h3, 8'hFF);
    rchk(spi_pkg::ADDR_CTRL2, 8'h00, "unmapped write");
    wr_reg(spi_pkg::ADDR_CTRL0, 8'h00);
    wr_reg(spi_pkg::ADDR_DATA, 8'h11);
    repeat (60) @(posedge clk);
    rchk(spi_pkg::ADDR_CTRL2, 8'h00, "disabled no frame");
    chk("pins released", {4'h0, active, sck_oe, sdo_oe, sel_oe}, 8'h00);
    $display("test reset and disable done");
    for (int m = 0; m < 5; m++) begin
      lp = m[1];
      le = m[0] ^ m[1];
      lo = m[0];
      cs = (m != 4);
      c2 = {2'b00, le, lp, lo, cs, 2'b00};
      tx = 8'hA5 ^ 8'(m);
      wr_reg(spi_pkg::ADDR_CTRL0, {3'(m), 5'h00});
      pol <= lp;
      eg <= le;
      ord <= lo;
      mtx <= 8'h3C + 8'(m);
      wr_reg(spi_pkg::ADDR_CTRL2, c2);
      wr_reg(spi_pkg::ADDR_CTRL0, {3'(m), 5'h02});
      repeat (20) @(posedge clk);
      chk("sck idle", {7'h0, sck_o}, {7'h0, lp});
      load(tx);
      wr_reg(spi_pkg::ADDR_DATA, 8'hFF);
      rchk(spi_pkg::ADDR_CTRL2, c2 | 8'h02, "collision");
      @(negedge clk);
      chk("select", {4'h0, sel_o, sel_oe, sck_oe, active}, {4'h0, 1'b0, cs, 2'b11});
      wait_irq();
      rchk(spi_pkg::ADDR_CTRL2, c2 | 8'h03, "flags");
      // Fastest mode samples the filtered input too late to be trusted
      if (m != 0) rchk(spi_pkg::ADDR_DATA, 8'h3C + 8'(m), "master rx");
      chk("master tx", m_rx, tx);
      wr_reg(spi_pkg::ADDR_CTRL2, c2);
      rchk(spi_pkg::ADDR_CTRL2, c2, "flags cleared");
      $display("test master mode %0d done", m);
    end
    for (int s = 0; s < 4; s++) begin
      lp = s[0];
      le = s[1];
      lo = ~s[0];
      cs = (s != 1);
      c2 = {2'b00, le, lp, lo, cs, 2'b00};
      tx = 8'h5A + 8'(s);
      wr_reg(spi_pkg::ADDR_CTRL0, {spi_pkg::MODE_SLAVE, 5'h00});
      pol <= lp;
      eg <= le;
      ord <= lo;
      mtx <= 8'hC3 ^ 8'(s);
      wr_reg(spi_pkg::ADDR_CTRL2, c2);
      // Let the new idle level pass the pin filter before enabling
      repeat (8) @(posedge clk);
      wr_reg(spi_pkg::ADDR_CTRL0, {spi_pkg::MODE_SLAVE, 5'h02});
      wr_reg(spi_pkg::ADDR_DATA, tx);
      if (s == 0) begin
        spi_far_model_inst.run_master(1'b0, mrx);
        chk("deselected oe", {7'h0, sdo_oe}, 8'h00);
        rchk(spi_pkg::ADDR_CTRL2, c2, "deselected");
      end
      fork
        spi_far_model_inst.run_master(cs, mrx);
        wait_irq();
      join
      chk("slave tx", mrx, tx);
      rchk(spi_pkg::ADDR_DATA, 8'hC3 ^ 8'(s), "slave rx");
      rchk(spi_pkg::ADDR_CTRL2, c2 | 8'h01, "slave done");
      $display("test slave shape %0d done", s);
    end
    stop_test();
  end
endmodule
